// file: design/boot_clock_reset_config.sv
// boot sequencer: internal reset, clock source, probe clocks, hand-off
// assumes pins are asynchronous to pclk and that the boot ROM drives
// the probe and finish steps over APB
`timescale 1ns/1ps

module boot_clock_reset_config
  import boot_clock_reset_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // configuration pins and reset sources
  input wire logic reset_pin_n,
  input wire logic core_supply_good,
  input wire logic core_regulator_enable_n,
  input wire logic clock_source_select,
  // core regulator control
  output logic core_regulator_output_en,
  output logic core_regulator_voltage_select,
  // clock routing
  output logic pll_bypass,
  output logic [9:0] pll_multiplier,
  output logic osc_to_pll,
  output logic osc_to_rtc,
  output logic sysclk_from_ext,
  output logic ext_clock_ignored,
  // reset and hand-off
  output logic internal_reset_n,
  output logic vector_fetch,
  output logic [23:0] reset_vector,
  output logic user_start,
  output logic boot_done,
  // peripheral and memory control
  output logic [`PERIPH_COUNT-1:0] periph_clk_en,
  output logic [`DOMAIN_COUNT-1:0] idle_cfg,
  output logic [`RAM_BLOCKS-1:0] ram_reserve_mask
);

  initial begin
    if (SETTLE_CYCLES < 1) begin
      $error("boot_clock_reset_config: SETTLE_CYCLES below 1");
    end
  end

  boot_st_t r;
  boot_st_t nxt;
  logic timer_elapsed;
  logic good_eff;
  logic reset_ok;
  logic setup_ph;
  logic access_wr;
  logic mapped;
  logic [31:0] rd_word;

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_first_general_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.timer_start),
    .elapsed(timer_elapsed),
    .running()
  );

  // a disabled regulator has no monitor, so supply good is forced
  assign good_eff = r.ldo_s2 | r.good_s2; // (R11) (R10)
  assign reset_ok = good_eff & r.rst_s2; // (R9)

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (apb_req.paddr)
      `OFS_CTRL: begin
        rd_word[`CTRL_VSEL] = r.vsel;
        rd_word[`CTRL_IDX_HI:`CTRL_IDX_LO] = r.probe_idx;
      end
      `OFS_STATUS: begin
        rd_word[2:0] = r.state;
        rd_word[3] = r.clk_sel;
        rd_word[4] = good_eff;
        rd_word[5] = timer_elapsed;
        rd_word[6] = r.ram_reserved;
        rd_word[7] = r.pll_bypass;
      end
      `OFS_PERIPH: begin
        rd_word[`PERIPH_COUNT-1:0] = r.periph_clk_en;
      end
      `OFS_IDLE: begin
        rd_word[`DOMAIN_COUNT-1:0] = r.idle_cfg;
      end
      `OFS_PLL: begin
        rd_word[9:0] = r.pll_mult;
        rd_word[16] = r.pll_bypass;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt = r;
    nxt.rst_s1 = reset_pin_n;
    nxt.rst_s2 = r.rst_s1;
    nxt.good_s1 = core_supply_good;
    nxt.good_s2 = r.good_s1;
    nxt.ldo_s1 = core_regulator_enable_n;
    nxt.ldo_s2 = r.ldo_s1;
    nxt.sel_s1 = clock_source_select;
    nxt.sel_s2 = r.sel_s1;
    // one registered stage so the release lands on a single edge
    nxt.int_rst_n = reset_ok; // (R9) (R17)
    nxt.timer_start = 1'b0;
    nxt.vector_fetch = 1'b0;
    nxt.user_start = 1'b0;

    // reads and errors are captured in setup so the answer is a flop
    if (setup_ph) begin
      nxt.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_word;
      nxt.pslverr = ~mapped;
    end

    // only control is writable; the PLL and timer stay out of reach
    if (access_wr && apb_req.paddr == `OFS_CTRL) begin // (R5)
      nxt.vsel = apb_req.pwdata[`CTRL_VSEL];
      if (r.state == PROBING) begin
        if (apb_req.pwdata[`CTRL_FINISH]) begin
          nxt.periph_clk_en = '0; // (R6)
          nxt.state = SETTLE_WAIT;
        end else if (apb_req.pwdata[`CTRL_PROBE_DONE]) begin
          nxt.periph_clk_en = '0; // (R6)
        end else if (apb_req.pwdata[`CTRL_PROBE_START]) begin
          nxt.probe_idx = apb_req.pwdata[`CTRL_IDX_HI:`CTRL_IDX_LO];
          nxt.periph_clk_en = `PERIPH_COUNT'(1) <<
            apb_req.pwdata[`CTRL_IDX_HI:`CTRL_IDX_LO]; // (R6)
        end
      end
    end

    case (r.state)
      RESET_HOLD: begin
        nxt.pll_bypass = 1'b1;
        nxt.periph_clk_en = '0;
        nxt.ram_reserved = 1'b1; // (R8)
        if (r.int_rst_n) begin
          // strap caught at release; the board keeps it static
          nxt.clk_sel = r.sel_s2; // (R13) (R14)
          nxt.vector_fetch = 1'b1; // (R16)
          nxt.state = FETCH_VECTOR;
        end
      end
      FETCH_VECTOR: begin
        nxt.state = CLOCK_SETUP;
      end
      CLOCK_SETUP: begin
        nxt.idle_cfg = `IDLE_BOOT;
        if (!r.clk_sel) begin
          nxt.pll_mult = `PLL_MULT; // (R1)
          nxt.pll_bypass = 1'b0; // (R1)
        end else begin
          nxt.pll_bypass = 1'b1; // (R2)
        end
        nxt.timer_start = 1'b1; // (R4)
        nxt.state = PROBING;
      end
      PROBING: begin
      end
      SETTLE_WAIT: begin
        nxt.periph_clk_en = '0;
        if (timer_elapsed) begin // (R4)
          nxt.idle_cfg = `IDLE_BOOT; // (R7)
          nxt.ram_reserved = 1'b0; // (R8)
          nxt.user_start = 1'b1;
          nxt.state = USER_RUN;
        end
      end
      USER_RUN: begin
        nxt.periph_clk_en = '0; // (R7)
      end
      default: begin
        nxt.state = RESET_HOLD;
      end
    endcase

    // any loss of either reset source restarts the whole boot
    if (!r.int_rst_n) begin // (R9)
      nxt.state = RESET_HOLD;
      nxt.pll_bypass = 1'b1;
      nxt.pll_mult = 10'h000;
      nxt.periph_clk_en = '0;
      nxt.idle_cfg = `IDLE_RESET;
      nxt.ram_reserved = 1'b1;
      nxt.user_start = 1'b0;
      nxt.vector_fetch = 1'b0;
      nxt.timer_start = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= RESET_HOLD;
      r.pll_bypass <= 1'b1;
      r.vsel <= `VSEL_RESET;
      r.idle_cfg <= `IDLE_RESET;
      r.ram_reserved <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign apb_rsp.pready = apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata = r.prdata;
  assign apb_rsp.pslverr = r.pslverr;

  // regulator floats when disabled; level follows the select bit
  assign core_regulator_output_en = ~r.ldo_s2; // (R10) (R11)
  assign core_regulator_voltage_select = r.vsel; // (R10)

  assign pll_bypass = r.pll_bypass; // (R2) (R16)
  assign pll_multiplier = r.pll_mult;
  assign osc_to_pll = ~r.clk_sel; // (R12)
  assign osc_to_rtc = 1'b1; // (R12)
  assign sysclk_from_ext = r.clk_sel; // (R2)
  assign ext_clock_ignored = ~r.clk_sel; // (R12)

  assign internal_reset_n = r.int_rst_n;
  assign vector_fetch = r.vector_fetch;
  assign reset_vector = `RESET_VECTOR; // (R16)
  assign user_start = r.user_start;
  assign boot_done = (r.state == USER_RUN);
  assign periph_clk_en = r.periph_clk_en;
  assign idle_cfg = r.idle_cfg;

  always_comb begin
    ram_reserve_mask = '0;
    ram_reserve_mask[`BOOT_RAM_BLOCK] = r.ram_reserved; // (R8)
  end

  pll_mult_a: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
    (r.state == PROBING && !r.clk_sel) |->
      (pll_multiplier == 10'h177 && !pll_bypass))
    else $error("generator not at x375 while probing");

  bypass_ext_a: assert property (@(posedge pclk) disable iff (!presetn) // (R2)
    (r.clk_sel && r.state != RESET_HOLD) |-> (pll_bypass && sysclk_from_ext))
    else $error("external clock selected but generator not bypassed");

  settle_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
    $rose(user_start) |-> $past(timer_elapsed))
    else $error("user code started before settle time");

  probe_clk_a: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
    (periph_clk_en != '0) |->
      (r.state == PROBING && $onehot(periph_clk_en)))
    else $error("peripheral clock running outside a single probe");

  user_clocks_a: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
    (r.state == USER_RUN) |->
      (periph_clk_en == '0 && idle_cfg == 16'hfffe))
    else $error("hand-off with clocks on or domains awake");

  ram_reserve_a: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
    ram_reserve_mask[31] == (r.state != USER_RUN))
    else $error("boot RAM block reservation wrong");

  reset_and_a: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
    !reset_ok |=> !internal_reset_n ##1 (r.state == RESET_HOLD))
    else $error("internal reset not taken on a lost source");

  regulator_a: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
    !r.ldo_s2 |-> (core_regulator_output_en &&
      core_regulator_voltage_select == r.vsel && good_eff == r.good_s2))
    else $error("enabled regulator output or monitor wrong");

  regulator_off_a: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
    r.ldo_s2 |-> (!core_regulator_output_en && good_eff))
    else $error("disabled regulator still driven or supply not good");

  osc_route_a: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
    osc_to_rtc && (osc_to_pll == !sysclk_from_ext) &&
      (ext_clock_ignored == !r.clk_sel))
    else $error("oscillator routing wrong");

  vector_a: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
    vector_fetch |-> (pll_bypass && reset_vector == 24'hff_ff00 &&
      r.state == FETCH_VECTOR))
    else $error("vector fetch with generator active or wrong address");

  release_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
    $rose(internal_reset_n) |-> ($past(reset_ok) && r.state == RESET_HOLD)
      ##1 (vector_fetch && r.state == FETCH_VECTOR))
    else $error("reset release not on the synchronised edge");

endmodule // boot_clock_reset_config

// file: design/boot_clock_reset_map.svh
// constants of the boot clock and reset sequencer: offsets, fields, counts
// assumes a 100 MHz pclk and 32-bit APB with byte addresses
//
// Contract
// (R1) with clock select low the generator multiplies the 32.768 kHz clock by 375 to give 12.288 MHz.
// (R2) with clock select high the generator is bypassed and the system clock comes from the external clock input.
// (R3) the board supplies 11.2896, 12.0 or 12.288 MHz on the external clock input when it is selected.
// (R4) the first general timer times 200 ms of bandgap settling and user code does not start before it ends.
// (R5) register entries in a boot image never change the clock generator, the PLL or the boot timer.
// (R6) a peripheral clock runs only while that peripheral is probed as a boot source.
// (R7) at hand-off every peripheral clock is off and every idle domain but the core is idled.
// (R8) single access RAM block 31 is reserved while booting and freed when boot completes.
// (R9) internal reset is the AND of core supply good and the external reset pin.
// (R10) with the regulator enabled its output is 1.3 V or 1.05 V by voltage select and supply good follows the monitor.
// (R11) with the regulator disabled its output floats and supply good is forced high.
// (R12) with clock select low the oscillator feeds RTC and generator and the clock input is ignored, else only RTC.
// (R13) the board holds configuration pins static and resets the device after changing one.
// (R14) the board never changes the clock select pin while the device runs.
// (R15) with an external core supply the board asserts the reset pin after power-up.
// (R16) after reset the core fetches its vector from 0xFFFF00 in ROM with the PLL bypassed.
// (R17) release of the combined reset is synchronised so all logic leaves reset on one edge.
`ifndef BOOT_CLOCK_RESET_MAP_SVH
`define BOOT_CLOCK_RESET_MAP_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PERIPH 12'h008
`define OFS_IDLE 12'h00c
`define OFS_PLL 12'h010

`define CTRL_PROBE_START 0
`define CTRL_PROBE_DONE 1
`define CTRL_FINISH 2
`define CTRL_VSEL 3
`define CTRL_IDX_LO 4
`define CTRL_IDX_HI 6

`define PERIPH_COUNT 8
`define DOMAIN_COUNT 16
`define RAM_BLOCKS 32
`define BOOT_RAM_BLOCK 31

`define PLL_MULT 10'h177
`define RESET_VECTOR 24'hff_ff00
`define VSEL_RESET 1'b1
`define IDLE_RESET 16'h0000
`define IDLE_BOOT 16'hfffe
`define CPU_DOMAIN 0

`define SETTLE_TIME_MS 200
`define CLK_KHZ 100000
`define SETTLE_CYCLES (`SETTLE_TIME_MS * `CLK_KHZ)

`endif

// file: design/boot_clock_reset_pkg.sv
// types shared by the boot sequencer and its settle timer
// assumes the map header is on the include path
`include "boot_clock_reset_map.svh"

package boot_clock_reset_pkg;

  typedef enum logic [2:0] {
    RESET_HOLD = 3'b000,
    FETCH_VECTOR = 3'b001,
    CLOCK_SETUP = 3'b010,
    PROBING = 3'b011,
    SETTLE_WAIT = 3'b100,
    USER_RUN = 3'b101
  } boot_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [31:0] count;
    logic running;
    logic elapsed;
  } timer_st_t;

  typedef struct packed {
    boot_state_t state;
    logic rst_s1;
    logic rst_s2;
    logic good_s1;
    logic good_s2;
    logic ldo_s1;
    logic ldo_s2;
    logic sel_s1;
    logic sel_s2;
    logic int_rst_n;
    logic clk_sel;
    logic pll_bypass;
    logic [9:0] pll_mult;
    logic timer_start;
    logic vector_fetch;
    logic user_start;
    logic vsel;
    logic [2:0] probe_idx;
    logic [`PERIPH_COUNT-1:0] periph_clk_en;
    logic [`DOMAIN_COUNT-1:0] idle_cfg;
    logic ram_reserved;
    logic [31:0] prdata;
    logic pslverr;
  } boot_st_t;

endpackage

// file: design/settle_timer.sv
// first general timer used as a one-shot settle counter
// assumes start is a one-cycle pulse on pclk
`timescale 1ns/1ps

module settle_timer
  import boot_clock_reset_pkg::*;
#(
  parameter int CYCLES = `SETTLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control and result
  input wire logic start,
  output logic elapsed,
  output logic running
);

  initial begin
    if (CYCLES < 1) begin
      $error("settle_timer: CYCLES must be at least 1");
    end
  end

  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  timer_st_t r;
  timer_st_t nxt;

  always_comb begin
    nxt = r;
    if (start) begin
      nxt.count = 32'h0000_0000;
      nxt.running = 1'b1;
      nxt.elapsed = 1'b0;
    end else if (r.running) begin
      if (r.count == LAST) begin
        nxt.running = 1'b0;
        nxt.elapsed = 1'b1;
      end else begin
        nxt.count = r.count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign elapsed = r.elapsed;
  assign running = r.running;

endmodule // settle_timer

// file: verif/board_pins_model.sv
// board side: strap pins, regulator enable, reset pin and supply monitor
// assumes the bench moves its controls by nonblocking assignment at pclk
`timescale 1ns/1ps

module board_pins_model #(
  parameter int EXT_CLK_KHZ = 12288
) (
  // clock
  input wire logic pclk,
  // bench controls
  input wire logic power_up,
  input wire logic hold_reset,
  input wire logic strap_sel,
  input wire logic ext_supply,
  input wire logic slow,
  // pins toward the device
  output logic reset_pin_n,
  output logic core_supply_good,
  output logic core_regulator_enable_n,
  output logic clock_source_select
);
  int ramp;

  initial begin
    reset_pin_n = 1'b0;
    core_supply_good = 1'b0;
    core_regulator_enable_n = 1'b0;
    clock_source_select = 1'b0;
    ramp = 0;
  end

  always @(posedge pclk) begin
    reset_pin_n <= !hold_reset;
    // straps move only under reset, so no boot relies on a stale pin
    if (hold_reset) begin
      clock_source_select <= strap_sel;
      core_regulator_enable_n <= ext_supply;
    end
    ramp <= power_up ? ramp + 1 : 0;
    // a bypassed monitor reads low: the device must not depend on it
    core_supply_good <= !core_regulator_enable_n && power_up &&
                        ramp > (slow ? 25 : 2);
  end
endmodule // board_pins_model

// file: verif/tb_top.sv
// bench for the boot clock and reset sequencer
// assumes the design package and map header are compiled before it
`timescale 1ns/1ps
`include "boot_clock_reset_map.svh"

module tb_top;
  import boot_clock_reset_pkg::*;
  localparam int SET = 40;
  logic pclk, presetn;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic reset_pin_n, core_supply_good, core_regulator_enable_n;
  logic clock_source_select, core_regulator_output_en;
  logic core_regulator_voltage_select, pll_bypass, osc_to_pll, osc_to_rtc;
  logic sysclk_from_ext, ext_clock_ignored, internal_reset_n, vector_fetch;
  logic user_start, boot_done;
  logic [9:0] pll_multiplier;
  logic [23:0] reset_vector;
  logic [7:0] periph_clk_en;
  logic [15:0] idle_cfg;
  logic [31:0] ram_reserve_mask;
  logic power_up, hold_reset, strap_sel, ext_supply, slow;
  int miscompares, samples_checked, cyc, rel;

  boot_clock_reset_config #(.SETTLE_CYCLES(SET)) i_boot_clock_reset_config (
    .pclk, .presetn, .apb_req, .apb_rsp, .reset_pin_n, .core_supply_good,
    .core_regulator_enable_n, .clock_source_select,
    .core_regulator_output_en, .core_regulator_voltage_select, .pll_bypass,
    .pll_multiplier, .osc_to_pll, .osc_to_rtc, .sysclk_from_ext,
    .ext_clock_ignored, .internal_reset_n, .vector_fetch, .reset_vector,
    .user_start, .boot_done, .periph_clk_en, .idle_cfg, .ram_reserve_mask);

  board_pins_model i_board_pins_model (
    .pclk, .power_up, .hold_reset, .strap_sel, .ext_supply, .slow,
    .reset_pin_n, .core_supply_good, .core_regulator_enable_n,
    .clock_source_select);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  // 32.768 kHz times 375 gives 12.288 MHz; bypass leaves no multiplier
  function automatic logic [9:0] exp_mult(input logic sel);
    return sel ? 10'h000 : 10'h177;
  endfunction

  function automatic logic [31:0] ctrl(input int i, input logic s, d, f);
    return {25'h0, i[2:0], 1'b1, f, d, s};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    #1;
  endtask

  task wrc(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
    chk(e, xe);
  endtask

  task end_test(input string s);
    $display("test %s done", s);
  endtask

  task boot(input logic sel, input logic ext, input logic slw);
    int n;
    @(posedge pclk);
    hold_reset <= 1'b1;
    strap_sel <= sel;
    ext_supply <= ext;
    slow <= slw;
    power_up <= 1'b1;
    repeat (40) @(posedge pclk);
    hold_reset <= 1'b0;
    @(posedge pclk);
    #1;
    chk(internal_reset_n, 1'b0);
    n = 0;
    while (internal_reset_n !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    rel = cyc;
    chk(n, 3);
    @(posedge pclk);
    #1;
    chk(vector_fetch, 1'b1);
    chk(reset_vector, 24'hff_ff00);
    chk(pll_bypass, 1'b1);
    // fetch, then clock setup: the generator is loaded on the edge after
    @(posedge pclk);
    #1;
    @(posedge pclk);
    #1;
    chk(pll_multiplier, exp_mult(sel));
    chk({pll_bypass, sysclk_from_ext}, {sel, sel});
    chk({osc_to_pll, ext_clock_ignored, osc_to_rtc}, {!sel, !sel, 1'b1});
    chk(core_regulator_output_en, !ext);
    chk(idle_cfg, 16'hfffe);
    chk(ram_reserve_mask, 32'h8000_0000);
    end_test("boot");
  endtask

  task wait_user();
    int n;
    n = 0;
    while (user_start !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(cyc - rel > SET, 1'b1);
    chk({boot_done, periph_clk_en}, 9'h100);
    chk(idle_cfg, 16'hfffe);
    chk(ram_reserve_mask, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk(user_start, 1'b0);
    end_test("handoff");
  endtask

  task finish_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #300_000;
    miscompares++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic e;
    int k, n;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    apb_req = '0;
    presetn = 1'b0;
    power_up = 1'b0;
    hold_reset = 1'b1;
    strap_sel = 1'b0;
    ext_supply = 1'b0;
    slow = 1'b1;
    void'($urandom(32'he8a7));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    boot(1'b0, 1'b0, 1'b1);
    // probing, oscillator path, supply good, block 31 held, timer running
    rdc(`OFS_STATUS, 32'h0000_0053, 1'b0);
    rdc(`OFS_IDLE, 32'h0000_fffe, 1'b0);
    rdc(`OFS_PLL, 32'h0000_0177, 1'b0);
    wrc(`OFS_PLL, 32'hffff_ffff);
    rdc(`OFS_PLL, 32'h0000_0177, 1'b0);
    rdc(12'h020, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h020, 32'h1234_5678, r, e);
    chk(e, 1'b1);
    wrc(`OFS_CTRL, 32'h0000_0000);
    chk(core_regulator_voltage_select, 1'b0);
    wrc(`OFS_CTRL, 32'h0000_0008);
    chk(core_regulator_voltage_select, 1'b1);
    end_test("config");
    for (int i = 0; i < 16; i++) begin
      k = i < 8 ? i : $urandom_range(7, 0);
      wrc(`OFS_CTRL, ctrl(k, 1'b1, 1'b0, 1'b0));
      chk(periph_clk_en, 8'h01 << k);
      rdc(`OFS_PERIPH, 32'h0000_0001 << k, 1'b0);
      // odd passes set start and done together: done must win
      wrc(`OFS_CTRL, ctrl(k, 1'b1, i[0], 1'b0));
      chk(periph_clk_en, i[0] ? 8'h00 : 8'h01 << k);
    end
    wrc(`OFS_CTRL, ctrl(3, 1'b1, 1'b0, 1'b0));
    wrc(`OFS_CTRL, ctrl(5, 1'b1, 1'b1, 1'b1));
    chk(periph_clk_en, 8'h00);
    end_test("probe");
    wait_user();
    wrc(`OFS_CTRL, ctrl(2, 1'b1, 1'b0, 1'b0));
    chk(periph_clk_en, 8'h00);
    @(posedge pclk);
    hold_reset <= 1'b1;
    @(posedge pclk);
    #1;
    n = 0;
    while (internal_reset_n !== 1'b0 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(n, 3);
    repeat (2) @(posedge pclk);
    #1;
    chk({boot_done, ram_reserve_mask}, 33'h0_8000_0000);
    end_test("reset loss");
    boot(1'b1, 1'b1, 1'b0);
    wrc(`OFS_CTRL, ctrl(0, 1'b0, 1'b0, 1'b1));
    wait_user();
    finish_test();
  end
endmodule // tb_top
